// File: verilog/antenna_diversity.sv
// Purpose: Antenna choice per received packet and clear-channel strength check
// Assumes: rxMode, txMode, bitTick, preambleStart and strengthIn come from core logic on mclk
// Notes: Register reads answer one cycle after the read strobe
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "antenna_diversity_defines.svh"

module antenna_diversity
#(
	parameter logic [7:0] MEAS_WINDOW = `MEAS_BITS,
	parameter logic [7:0] BEACON_WINDOW = `BEACON_BITS,
	parameter logic [7:0] DWELL = `DWELL_BITS
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic rxMode,
	input wire logic txMode,
	input wire logic bitTick,
	input wire logic preambleStart,
	input wire logic [7:0] strengthIn,
	output antenna_diversity_pkg::antenna_pair_t antenna,
	output logic pinOut,
	output logic irq
);
	antenna_diversity_pkg::div_state_t state;
	logic [7:0] opControl, threshold, irqStatus, irqMask, strength;
	logic [3:0] pinFunction;
	logic [7:0] bitCount, levelA, levelB, bestLevel, window, setBits, clearBits;
	logic refresh, antSel, rxLast, evalDone, ccaStatus;
	logic [2:0] divMode;
	logic autoMode, beacon, active, idleLevel, windowEnd;

	assign divMode = opControl[`DIV_MSB:`DIV_LSB];
	assign autoMode = divMode[2];
	assign beacon = divMode[2] && divMode[1];
	assign active = rxMode || txMode;
	assign idleLevel = autoMode ? divMode[0] : divMode[1];
	assign window = beacon ? BEACON_WINDOW : MEAS_WINDOW;
	assign windowEnd = bitTick && bitCount == window - 8'h01;

	strength_sampler sampler
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.bitTick(bitTick),
		.strengthIn(strengthIn),
		.strength(strength),
		.refresh(refresh)
	);

	// Control and configuration registers
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			opControl <= `RST_OPCTL_TWO;
			threshold <= `RST_THRESHOLD;
			irqMask <= `RST_IRQ_MASK;
			pinFunction <= `RST_PIN_FUNCTION;
		end
		else if (regWrite)
		begin
			if (regAddr == `OFS_OPCTL_TWO)
				opControl <= regWdata;
			else if (regAddr == `OFS_THRESHOLD)
				threshold <= regWdata;
			else if (regAddr == `OFS_IRQ_MASK)
				irqMask <= regWdata;
			else if (regAddr == `OFS_PIN_FUNCTION)
				pinFunction <= regWdata[3:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || !regRead)
			regRdata <= 8'h00;
		else if (regAddr == `OFS_IRQ_STATUS)
			regRdata <= irqStatus;
		else if (regAddr == `OFS_IRQ_MASK)
			regRdata <= irqMask;
		else if (regAddr == `OFS_OPCTL_TWO)
			regRdata <= opControl;
		else if (regAddr == `OFS_PIN_FUNCTION)
			regRdata <= {4'h0, pinFunction};
		else if (regAddr == `OFS_STRENGTH)
			regRdata <= strength;
		else if (regAddr == `OFS_THRESHOLD)
			regRdata <= threshold;
		else
			regRdata <= 8'h00;
	end

	// Diversity sequencer
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rxLast <= 1'b0;
		else
			rxLast <= rxMode;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state <= antenna_diversity_pkg::ST_IDLE;
		else
			case (state)
				antenna_diversity_pkg::ST_IDLE:
					if (rxMode && !rxLast)
						state <= beacon ? antenna_diversity_pkg::ST_MEAS_A
							: antenna_diversity_pkg::ST_TOGGLE;
				antenna_diversity_pkg::ST_TOGGLE:
					if (!rxMode)
						state <= antenna_diversity_pkg::ST_IDLE;
					else if (preambleStart)
						state <= antenna_diversity_pkg::ST_MEAS_A;
				antenna_diversity_pkg::ST_MEAS_A:
					if (!rxMode)
						state <= antenna_diversity_pkg::ST_IDLE;
					else if (windowEnd)
						state <= autoMode ? antenna_diversity_pkg::ST_MEAS_B
							: antenna_diversity_pkg::ST_HOLD;
				antenna_diversity_pkg::ST_MEAS_B:
					if (!rxMode)
						state <= antenna_diversity_pkg::ST_IDLE;
					else if (windowEnd)
						state <= antenna_diversity_pkg::ST_HOLD;
				antenna_diversity_pkg::ST_HOLD:
					if (!rxMode)
						state <= antenna_diversity_pkg::ST_IDLE;
				default:
					state <= antenna_diversity_pkg::ST_IDLE;
			endcase
	end

	// Bit counter for the dwell and measurement windows
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			bitCount <= 8'h00;
		else if (state == antenna_diversity_pkg::ST_IDLE || (preambleStart
			&& state == antenna_diversity_pkg::ST_TOGGLE) || windowEnd)
			bitCount <= 8'h00;
		else if (state == antenna_diversity_pkg::ST_TOGGLE && bitTick && bitCount == DWELL - 8'h01)
			bitCount <= 8'h00;
		else if (bitTick)
			bitCount <= bitCount + 8'h01;
	end

	// Antenna choice; held through transmit so the reply reuses it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			antSel <= 1'b0;
			levelA <= 8'h00;
			levelB <= 8'h00;
		end
		else
			case (state)
				antenna_diversity_pkg::ST_IDLE:
					if (rxMode && !rxLast && autoMode)
						antSel <= 1'b0;
				antenna_diversity_pkg::ST_TOGGLE:
					if (preambleStart)
						antSel <= 1'b0;
					else if (bitTick && bitCount == DWELL - 8'h01)
						antSel <= !antSel;
				antenna_diversity_pkg::ST_MEAS_A:
					if (windowEnd)
					begin
						levelA <= strengthIn;
						levelB <= 8'h00;
						if (autoMode)
							antSel <= 1'b1;
					end
				antenna_diversity_pkg::ST_MEAS_B:
					if (windowEnd)
					begin
						levelB <= strengthIn;
						antSel <= strengthIn > levelA;
					end
			endcase
	end

	assign bestLevel = levelB > levelA ? levelB : levelA;

	// Evaluation finishes at the end of the last window
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			evalDone <= 1'b0;
		else
			evalDone <= windowEnd && rxMode && (state == antenna_diversity_pkg::ST_MEAS_B
				|| (state == antenna_diversity_pkg::ST_MEAS_A && !autoMode));
	end

	// Held until the next evaluation replaces it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ccaStatus <= 1'b0;
		else if (evalDone)
			ccaStatus <= bestLevel > threshold;
	end

	// Sticky status, write one to clear; a set in the same cycle wins
	always_comb
	begin
		setBits = 8'h00;
		setBits[`IRQ_STRENGTH_BIT] = evalDone && bestLevel > threshold;
		setBits[`IRQ_EVAL_BIT] = evalDone;
		clearBits = (regWrite && regAddr == `OFS_IRQ_STATUS) ? regWdata : 8'h00;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irqStatus <= 8'h00;
		else
			irqStatus <= (irqStatus & ~clearBits) | setBits;
	end

	assign irq = |(irqStatus & irqMask);

	// Output drive; fixed codes ignore the sequencer
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			antenna <= '0;
			pinOut <= 1'b0;
		end
		else
		begin
			pinOut <= pinFunction == `PIN_FN_CCA && ccaStatus;
			if (!active)
			begin
				antenna.one <= idleLevel;
				antenna.two <= idleLevel;
			end
			else if (!autoMode)
			begin
				antenna.one <= divMode[0];
				antenna.two <= !divMode[0];
			end
			else
			begin
				antenna.one <= antSel;
				antenna.two <= !antSel;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_fixed;
		active && !autoMode |=> antenna.one == $past(divMode[0]) && antenna.two != antenna.one;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed antenna wrong");
	property p_idle;
		!active |=> antenna.one == $past(idleLevel) && antenna.two == $past(idleLevel);
	endproperty
	a_idle: assert property (p_idle) else $error("idle antenna level wrong");
	property p_toggle;
		state == antenna_diversity_pkg::ST_TOGGLE && !preambleStart && bitTick
			&& bitCount == DWELL - 8'h01 |=> antSel != $past(antSel);
	endproperty
	a_toggle: assert property (p_toggle) else $error("antenna did not alternate");
	property p_pick;
		state == antenna_diversity_pkg::ST_MEAS_B && windowEnd
			|=> antSel == ($past(strengthIn) > $past(levelA));
	endproperty
	a_pick: assert property (p_pick) else $error("weaker antenna chosen");
	property p_hold;
		state == antenna_diversity_pkg::ST_HOLD && rxMode |=> $stable(antSel);
	endproperty
	a_hold: assert property (p_hold) else $error("choice changed in packet");
	// Output register lags the choice by one cycle, also on the last transmit cycle
	property p_tx;
		txMode && autoMode && !rxMode
			|=> antenna.one == $past(antSel) && antenna.two != antenna.one;
	endproperty
	a_tx: assert property (p_tx) else $error("transmit antenna not reused");
	property p_flag;
		evalDone && bestLevel > threshold |=> irqStatus[`IRQ_STRENGTH_BIT];
	endproperty
	a_flag: assert property (p_flag) else $error("strength flag not set");
	property p_irq;
		irq == (irqStatus[`IRQ_STRENGTH_BIT] && irqMask[`IRQ_STRENGTH_BIT]
			|| |(irqStatus & irqMask & 8'hef));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt gating wrong");
	property p_pin;
		pinFunction != `PIN_FN_CCA |=> !pinOut;
	endproperty
	a_pin: assert property (p_pin) else $error("pin driven without function");
	property p_cfg;
		regWrite && regAddr == `OFS_OPCTL_TWO ##1 regRead && regAddr == `OFS_OPCTL_TWO
			|=> regRdata == $past(regWdata, 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("control readback wrong");

	c_eval: cover property (evalDone && autoMode && !beacon);
	c_beacon: cover property (evalDone && beacon);
	c_irq: cover property (irq && irqStatus[`IRQ_STRENGTH_BIT]);
	c_tx: cover property (state == antenna_diversity_pkg::ST_HOLD ##[1:50] txMode);
	c_refresh: cover property (refresh && regRead && regAddr == `OFS_STRENGTH);
endmodule

// File: verilog/antenna_diversity_defines.svh
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: 8-bit register space reached over a plain strobe port
// Notes: Included by both design modules of the diversity block
`ifndef ANTENNA_DIVERSITY_DEFINES_SVH
`define ANTENNA_DIVERSITY_DEFINES_SVH

`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h06
`define OFS_OPCTL_TWO 8'h08
`define OFS_PIN_FUNCTION 8'h0b
`define OFS_STRENGTH 8'h26
`define OFS_THRESHOLD 8'h27

`define RST_OPCTL_TWO 8'h00
`define RST_THRESHOLD 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_PIN_FUNCTION 4'h0

`define DIV_MSB 7
`define DIV_LSB 5
`define IRQ_STRENGTH_BIT 4
`define IRQ_EVAL_BIT 6
`define PIN_FN_CCA 4'he

`define REFRESH_BITS 3'h4
`define MEAS_BITS 8'h10
`define BEACON_BITS 8'h08
`define DWELL_BITS 8'h04

`endif

// File: verilog/antenna_diversity_pkg.sv
// Purpose: Types shared by the diversity block
// Assumes: Constants live in the defines header
// Notes: No numbers here beyond state codes
package antenna_diversity_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_TOGGLE = 3'b001,
		ST_MEAS_A = 3'b010,
		ST_MEAS_B = 3'b011,
		ST_HOLD = 3'b100
	} div_state_t;

	typedef struct packed
	{
		logic one;
		logic two;
	} antenna_pair_t;
endpackage

// File: verilog/strength_sampler.sv
// Purpose: Holds the published signal strength, refreshed every few bit periods
// Assumes: bitTick is one pulse per bit period on mclk
// Notes: Refresh is one clock wide; a read in that cycle sees the new value
`timescale 1ns/1ps
`include "antenna_diversity_defines.svh"
module strength_sampler
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic bitTick,
	input wire logic [7:0] strengthIn,
	output logic [7:0] strength,
	output logic refresh
);
	logic [2:0] bitCount;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			bitCount <= 3'h0;
		else if (bitTick)
			bitCount <= (bitCount == `REFRESH_BITS - 3'h1) ? 3'h0 : bitCount + 3'h1;
	end

	// One update per four bit periods
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			strength <= 8'h00;
			refresh <= 1'b0;
		end
		else
		begin
			refresh <= bitTick && bitCount == `REFRESH_BITS - 3'h1;
			if (bitTick && bitCount == `REFRESH_BITS - 3'h1)
				strength <= strengthIn;
		end
	end

	property p_refresh;
		@(posedge mclk) disable iff (!rst_n)
		refresh |-> strength == $past(strengthIn);
	endproperty
	a_refresh: assert property (p_refresh) else $error("strength not refreshed");
endmodule

// File: tb/rf_front_model.sv
// Purpose: Stand-in for the RF switch, both antennas and the core bit timing
// Assumes: Level reported is that of the antenna the switch routes
// Notes: With neither or both paths routed the level wanders every cycle
`timescale 1ns/1ps
module rf_front_model
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire antenna_diversity_pkg::antenna_pair_t antenna,
	input wire logic [7:0] levelOne,
	input wire logic [7:0] levelTwo,
	output logic bitTick,
	output logic [7:0] strengthIn
);
	int cnt = 0;
	logic [7:0] noise = 8'h5a;
	always @(posedge mclk)
	begin
		noise <= noise + 8'h35;
		cnt <= (!rst_n || cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
	end
	assign bitTick = rst_n && cnt == TICK_CYCLES - 1;
	// Unrouted switch gives no stable level, so no stale value can pass
	assign strengthIn = (antenna.one == antenna.two) ? noise :
		(antenna.one ? levelOne : levelTwo);
endmodule

// File: tb/antenna_diversity_tb.sv
// Purpose: Self-checking bench for the antenna diversity block
// Assumes: Bit period of four clocks from the front model
// Notes: Random levels, thresholds and masks from a fixed seed
`timescale 1ns/1ps
`include "antenna_diversity_defines.svh"
module antenna_diversity_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdata;
	logic rxMode = 1'b0;
	logic txMode = 1'b0;
	logic preambleStart = 1'b0;
	logic bitTick;
	logic [7:0] strengthIn;
	logic [7:0] levelOne = 8'h00;
	logic [7:0] levelTwo = 8'h00;
	antenna_diversity_pkg::antenna_pair_t antenna;
	logic pinOut;
	logic irq;
	logic [7:0] rdv;
	int errors = 0;
	int nChecks = 0;

	antenna_diversity i_dut
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdata(regRdata),
		.rxMode(rxMode),
		.txMode(txMode),
		.bitTick(bitTick),
		.preambleStart(preambleStart),
		.strengthIn(strengthIn),
		.antenna(antenna),
		.pinOut(pinOut),
		.irq(irq)
	);

	rf_front_model i_front
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.antenna(antenna),
		.levelOne(levelOne),
		.levelTwo(levelTwo),
		.bitTick(bitTick),
		.strengthIn(strengthIn)
	);

	initial
	begin
		forever #20 mclk = ~mclk;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", nChecks, errors);
		if (errors == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chkReg(input string what, input logic [7:0] exp, input logic [7:0] got);
		nChecks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkPins(input string what, input logic [1:0] exp, input logic [1:0] got);
		nChecks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		rdv = regRdata;
	endtask

	// Write then read back with no idle cycle between the strobes
	task automatic wrRd(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		rdv = regRdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	function automatic logic [1:0] idlePins(input logic [2:0] c);
		return {2{c[2] ? c[0] : c[1]}};
	endfunction

	task automatic runDiv(input logic [2:0] code);
		logic [7:0] thr;
		logic [7:0] mask;
		logic [7:0] lo;
		logic [7:0] lt;
		logic [7:0] best;
		logic cca;
		logic last;
		int flips;
		thr = 8'($urandom);
		mask = 8'($urandom) & 8'h10;
		lo = 8'($urandom_range(0, 254));
		lt = 8'($urandom_range(0, 254));
		if (lt == lo)
			lt = lo + 8'h01;
		best = (lo > lt) ? lo : lt;
		cca = best > thr;
		levelOne <= lo;
		levelTwo <= lt;
		wr(`OFS_IRQ_STATUS, 8'hff);
		wr(`OFS_IRQ_MASK, mask);
		wr(`OFS_THRESHOLD, thr);
		rd(`OFS_THRESHOLD);
		chkReg("threshold", thr, rdv);
		wr(`OFS_PIN_FUNCTION, {4'h0, `PIN_FN_CCA});
		wr(`OFS_OPCTL_TWO, {code, 5'h00});
		@(posedge mclk);
		rxMode <= 1'b1;
		if (!code[1])
		begin
			flips = 0;
			last = antenna.one;
			repeat (48)
			begin
				settle(1);
				flips += (antenna.one !== last);
				last = antenna.one;
			end
			chkReg("toggle seen", 8'h01, 8'(flips >= 2));
			@(posedge mclk);
			preambleStart <= 1'b1;
			@(posedge mclk);
			preambleStart <= 1'b0;
		end
		// Sender keeps the preamble up for both full measuring windows
		repeat (2 * (code[1] ? `BEACON_BITS : `MEAS_BITS) + 1) @(posedge bitTick);
		settle(6);
		chkPins("chosen pins", {lo > lt, !(lo > lt)}, antenna);
		chkReg("pin out", {7'h00, cca}, {7'h00, pinOut});
		chkReg("irq", {7'h00, cca & mask[4]}, {7'h00, irq});
		rd(`OFS_IRQ_STATUS);
		chkReg("status", {3'b010, cca, 4'h0}, rdv & 8'h50);
		// Host reads only once the level is steady, never near a refresh
		repeat (6) @(posedge bitTick);
		wr(`OFS_STRENGTH, ~best);
		rd(`OFS_STRENGTH);
		chkReg("strength", best, rdv);
		@(posedge mclk);
		rxMode <= 1'b0;
		txMode <= 1'b1;
		settle(3);
		chkPins("tx pins", {lo > lt, !(lo > lt)}, antenna);
		@(posedge mclk);
		txMode <= 1'b0;
		settle(3);
		chkPins("idle pins", idlePins(code), antenna);
		chkReg("pin held", {7'h00, cca}, {7'h00, pinOut});
		wr(`OFS_IRQ_STATUS, 8'h50);
		rd(`OFS_IRQ_STATUS);
		chkReg("status cleared", 8'h00, rdv & 8'h50);
		chkReg("irq cleared", 8'h00, {7'h00, irq});
		$display("test diversity code %b done", code);
	endtask

	initial
	begin
		void'($urandom(42186));
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`OFS_OPCTL_TWO);
		chkReg("control reset", `RST_OPCTL_TWO, rdv);
		rd(`OFS_THRESHOLD);
		chkReg("threshold reset", `RST_THRESHOLD, rdv);
		for (int c = 0; c < 8; c++)
		begin
			wrRd(`OFS_OPCTL_TWO, {c[2:0], 5'h00});
			chkReg("control code", {c[2:0], 5'h00}, rdv);
			settle(2);
			chkPins("idle pins", idlePins(c[2:0]), antenna);
			if (c < 4)
			begin
				@(posedge mclk);
				rxMode <= 1'b1;
				settle(3);
				chkPins("fixed pins", {c[0], ~c[0]}, antenna);
				@(posedge mclk);
				rxMode <= 1'b0;
			end
		end
		$display("test codes done");
		// Fixed code 001 routes antenna one; only window A is evaluated
		levelOne <= 8'h90;
		levelTwo <= 8'h20;
		wr(`OFS_THRESHOLD, 8'h40);
		wr(`OFS_OPCTL_TWO, 8'h20);
		@(posedge mclk);
		rxMode <= 1'b1;
		settle(8);
		@(posedge mclk);
		preambleStart <= 1'b1;
		@(posedge mclk);
		preambleStart <= 1'b0;
		repeat (`MEAS_BITS + 1) @(posedge bitTick);
		settle(6);
		rd(`OFS_IRQ_STATUS);
		chkReg("fixed status", 8'h50, rdv & 8'h50);
		@(posedge mclk);
		rxMode <= 1'b0;
		$display("test fixed evaluation done");
		for (int i = 0; i < 8; i++)
			runDiv(3'(4 + i % 4));
		wr(8'h55, 8'hff);
		rd(8'h55);
		chkReg("unmapped", 8'h00, rdv);
		$display("test unmapped done");
		stop_test;
	end

	// Whole run is under two thousand cycles; this leaves ample slack
	initial
	begin
		#(40ns * 20000);
		errors++;
		stop_test;
	end
endmodule
